//--- common/imrx_defines.svh
// Purpose: Offsets, fields, reset values and fetch timing of the receive
//          message buffer read side.
// Assumes: Register index times four is the AHB byte address.
// Notes:   Definitions only.
`ifndef IMRX_DEFINES_SVH
`define IMRX_DEFINES_SVH

// Register word indices
`define IMRX_IDX_DATA_HI    30'h0000_0096
`define IMRX_IDX_DATA_LO    30'h0000_0097
`define IMRX_IDX_CTRL       30'h0000_0099
`define IMRX_IDX_AUX        30'h0000_009a
`define IMRX_IDX_STAT       30'h0000_009b

// Control register fields and reset
`define IMRX_CTRL_RST       3'h0
`define IMRX_CTRL_BYPASS    0
`define IMRX_CTRL_CRCREV    1
`define IMRX_CTRL_FAST      2
`define IMRX_CTRL_W         3

// Status register write field
`define IMRX_SYNC_BIT       0

// Fetch time in system clock cycles, fast read removes one
`define IMRX_SYNC_FETCH_CYC 3'h5
`define IMRX_LOW_FETCH_CYC  3'h4

// Buffer shape
`define IMRX_MSG_MAX        4'h8
`define IMRX_LAST_WORD      3'h7

`define IMRX_HRESP_OKAY     1'h0

`endif

//--- common/imrx_pkg.sv
// Purpose: Types of the receive message buffer read side.
// Assumes: Nothing.
// Notes:   Constants live in imrx_defines.svh.
package imrx_pkg;

    typedef enum logic [1:0] {
        IMRX_F_IDLE = 2'h0,
        IMRX_F_SYNC = 2'h1,
        IMRX_F_READ = 2'h2
    } imrx_fetch_t;

endpackage

//--- hw/imrx_mem.sv
// Purpose: Message buffer RAM, one write and one registered read port.
// Assumes: Single clock.
// Notes:   Disabled RAM holds its read data.
`timescale 1ns/1ns
`default_nettype none

module imrx_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic             clk,
    input  wire logic             en,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (en && we) begin
            mem[waddr] <= wdata;
        end
        if (en) begin
            rdata <= mem[raddr];
        end
    end

endmodule

`default_nettype wire

//--- hw/imrx_top.sv
// Purpose: Receive message buffer read side with AHB-Lite register access.
// Assumes: Deframer on hclk gives words, then a done pulse with header.
// Notes:   One wait state on every bus access.
`timescale 1ns/1ns
`default_nettype none

module imrx_top
    import imrx_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 64
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        rx_word_valid,
    input  wire logic [31:0] rx_word,
    input  wire logic        rx_msg_done,
    input  wire logic [7:0]  rx_hdr_aux,
    input  wire logic [1:0]  rx_hdr_link,
    input  wire logic [1:0]  rx_hdr_page,
    input  wire logic [2:0]  rx_hdr_user,
    input  wire logic [15:0] rx_crc_recv,
    input  wire logic [15:0] rx_crc_calc,
    input  wire logic        working_inband_channel_sel,
    output logic             user_bit_output_pin,
    output logic             ingress_mem_switch_page,
    output logic             egress_mem_switch_page
);

`include "imrx_defines.svh"

    function automatic logic [15:0] bit_rev(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic                      pend_r,  pend_nxt;
    logic                      wr_r,    wr_nxt;
    logic [29:0]               idx_r,   idx_nxt;
    logic                      rdy_r,   rdy_nxt;
    logic [31:0]               read_word_r,  read_word_nxt;
    logic [`IMRX_CTRL_W-1:0]   ctrl_r,  ctrl_nxt;
    logic                      sync_req;
    logic                      rd_lo;
    logic                      bypass;
    logic                      fast;
    logic                      hdr_upd_r;
    logic                      status_valid;
    logic [15:0]               stat_word;

    // Receive and read state, declared here for the read mux
    logic [3:0]  level_r,   level_nxt;
    logic [31:0] data_r,    data_nxt;
    logic        busy_r,    busy_nxt;
    logic        sdone_r,   sdone_nxt;
    logic        crc_hd_r,  crc_hd_nxt;
    logic        hdr_err_r, hdr_err_nxt;
    logic [7:0]  aux_r,     aux_nxt;
    logic [1:0]  link_r,    link_nxt;
    logic [1:0]  page_r,    page_nxt;
    logic [2:0]  user_r,    user_nxt;

    assign bypass       = ctrl_r[`IMRX_CTRL_BYPASS];
    assign fast         = ctrl_r[`IMRX_CTRL_FAST];
    assign status_valid = ~hdr_upd_r;
    assign sync_req     = pend_r && wr_r && idx_r == `IMRX_IDX_STAT
                          && hwdata[`IMRX_SYNC_BIT];
    assign rd_lo        = pend_r && !wr_r && idx_r == `IMRX_IDX_DATA_LO;
    assign stat_word    = {status_valid, link_r, page_r, user_r, crc_hd_r,
                           hdr_err_r, level_r, busy_r, sdone_r};

    always_comb begin
        pend_nxt = pend_r;
        wr_nxt   = wr_r;
        idx_nxt  = idx_r;
        rdy_nxt  = rdy_r;
        read_word_nxt = read_word_r;
        ctrl_nxt = ctrl_r;
        if (pend_r) begin
            pend_nxt = 1'b0;
            rdy_nxt  = 1'b1;
            read_word_nxt = 32'h0000_0000;
            if (wr_r) begin
                if (idx_r == `IMRX_IDX_CTRL) begin
                    ctrl_nxt = hwdata[`IMRX_CTRL_W-1:0];
                end
            end else if (idx_r == `IMRX_IDX_DATA_HI) begin
                read_word_nxt = {16'h0000, data_r[31:16]};
            end else if (idx_r == `IMRX_IDX_DATA_LO) begin
                read_word_nxt = {16'h0000, data_r[15:0]};
            end else if (idx_r == `IMRX_IDX_CTRL) begin
                read_word_nxt = {29'h0000_0000, ctrl_r};
            end else if (idx_r == `IMRX_IDX_AUX) begin
                read_word_nxt = {16'h0000, status_valid, 7'h00, aux_r};
            end else if (idx_r == `IMRX_IDX_STAT) begin
                read_word_nxt = {16'h0000, stat_word};
            end
        end else if (hsel && htrans[1] && hready) begin
            pend_nxt = 1'b1;
            rdy_nxt  = 1'b0;
            wr_nxt   = hwrite;
            idx_nxt  = haddr[31:2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_r <= 1'b0;
            wr_r   <= 1'b0;
            idx_r  <= 30'h0000_0000;
            rdy_r  <= 1'b1;
            read_word_r <= 32'h0000_0000;
            ctrl_r <= `IMRX_CTRL_RST;
            hresp  <= `IMRX_HRESP_OKAY;
        end else begin
            pend_r <= pend_nxt;
            wr_r   <= wr_nxt;
            idx_r  <= idx_nxt;
            rdy_r  <= rdy_nxt;
            read_word_r <= read_word_nxt;
            ctrl_r <= ctrl_nxt;
            hresp  <= `IMRX_HRESP_OKAY;
        end
    end

    assign hreadyout = rdy_r;
    assign hrdata    = read_word_r;

    ////////////////////////////////////////////////////////////////////////
    // Message reception
    logic [2:0] wslot_r,  wslot_nxt;
    logic [2:0] wcnt_r,   wcnt_nxt;
    logic [7:0] serr_r,   serr_nxt;
    logic       upd_nxt;
    logic       usr_pin_nxt, ing_nxt, egr_nxt;
    logic       crc_bad;
    logic       mem_we;
    logic       lvl_inc;
    logic       lvl_dec;

    assign crc_bad = (ctrl_r[`IMRX_CTRL_CRCREV] ? bit_rev(rx_crc_calc)
                      : rx_crc_calc) != rx_crc_recv;
    assign mem_we  = rx_word_valid && !bypass
                     && level_r != `IMRX_MSG_MAX;

    always_comb begin
        wslot_nxt   = wslot_r;
        wcnt_nxt    = wcnt_r;
        serr_nxt    = serr_r;
        hdr_err_nxt = hdr_err_r;
        aux_nxt     = aux_r;
        link_nxt    = link_r;
        page_nxt    = page_r;
        user_nxt    = user_r;
        upd_nxt     = 1'b0;
        lvl_inc     = 1'b0;
        usr_pin_nxt = user_bit_output_pin;
        ing_nxt     = ingress_mem_switch_page;
        egr_nxt     = egress_mem_switch_page;
        if (mem_we) begin
            wcnt_nxt = wcnt_r + 3'h1;
        end
        if (rx_msg_done && !bypass) begin
            wcnt_nxt    = 3'h0;
            hdr_err_nxt = crc_bad;
            if (!crc_bad) begin
                aux_nxt  = rx_hdr_aux;
                link_nxt = rx_hdr_link;
                page_nxt = rx_hdr_page;
                user_nxt = rx_hdr_user;
                upd_nxt  = 1'b1;
            end
            if (level_r != `IMRX_MSG_MAX) begin
                serr_nxt[wslot_r] = crc_bad;
                wslot_nxt         = wslot_r + 3'h1;
                lvl_inc           = 1'b1;
            end
        end
        if (working_inband_channel_sel) begin
            usr_pin_nxt = user_r[2];
            ing_nxt     = page_r[1];
            egr_nxt     = page_r[0];
        end
        level_nxt = level_r + {3'h0, lvl_inc} - {3'h0, lvl_dec};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wslot_r                 <= 3'h0;
            wcnt_r                  <= 3'h0;
            serr_r                  <= 8'h00;
            hdr_err_r               <= 1'b0;
            aux_r                   <= 8'h00;
            link_r                  <= 2'h0;
            page_r                  <= 2'h0;
            user_r                  <= 3'h0;
            hdr_upd_r               <= 1'b0;
            level_r                 <= 4'h0;
            user_bit_output_pin     <= 1'b0;
            ingress_mem_switch_page <= 1'b0;
            egress_mem_switch_page  <= 1'b0;
        end else begin
            wslot_r                 <= wslot_nxt;
            wcnt_r                  <= wcnt_nxt;
            serr_r                  <= serr_nxt;
            hdr_err_r               <= hdr_err_nxt;
            aux_r                   <= aux_nxt;
            link_r                  <= link_nxt;
            page_r                  <= page_nxt;
            user_r                  <= user_nxt;
            hdr_upd_r               <= upd_nxt;
            level_r                 <= level_nxt;
            user_bit_output_pin     <= usr_pin_nxt;
            ingress_mem_switch_page <= ing_nxt;
            egress_mem_switch_page  <= egr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read pointer and prefetch
    imrx_fetch_t st_r,     st_nxt;
    logic [2:0]  rslot_r,  rslot_nxt;
    logic [2:0]  rword_r,  rword_nxt;
    logic        touch_r,  touch_nxt;
    logic        skip_r,   skip_nxt;
    logic [2:0]  cnt_r,    cnt_nxt;
    logic        adv;
    logic [31:0] mem_rdata;

    assign adv = (touch_r || skip_r) && level_r != 4'h0;

    always_comb begin
        st_nxt     = st_r;
        rslot_nxt  = rslot_r;
        rword_nxt  = rword_r;
        touch_nxt  = touch_r;
        skip_nxt   = skip_r;
        cnt_nxt    = cnt_r;
        busy_nxt   = busy_r;
        sdone_nxt  = sdone_r;
        data_nxt   = data_r;
        crc_hd_nxt = crc_hd_r;
        lvl_dec    = 1'b0;
        case (st_r)
            IMRX_F_IDLE: begin
            end
            default: begin
                if (cnt_r == 3'h0) begin
                    data_nxt   = mem_rdata;
                    crc_hd_nxt = serr_r[rslot_r];
                    busy_nxt   = 1'b0;
                    st_nxt     = IMRX_F_IDLE;
                    if (st_r == IMRX_F_SYNC) begin
                        sdone_nxt = 1'b1;
                        skip_nxt  = 1'b1;
                    end
                end else begin
                    cnt_nxt = cnt_r - 3'h1;
                end
            end
        endcase
        if (sync_req) begin
            if (adv) begin
                rslot_nxt = rslot_r + 3'h1;
                lvl_dec   = 1'b1;
            end
            rword_nxt = 3'h0;
            touch_nxt = 1'b0;
            skip_nxt  = 1'b0;
            sdone_nxt = 1'b0;
            busy_nxt  = 1'b1;
            st_nxt    = IMRX_F_SYNC;
            cnt_nxt   = `IMRX_SYNC_FETCH_CYC - 3'h1 - {2'h0, fast};
        end else if (rd_lo) begin
            rword_nxt = rword_r + 3'h1;
            touch_nxt = 1'b1;
            skip_nxt  = 1'b0;
            if (rword_r == `IMRX_LAST_WORD && level_r != 4'h0) begin
                rslot_nxt = rslot_r + 3'h1;
                lvl_dec   = 1'b1;
                touch_nxt = 1'b0;
            end
            if (rword_r != `IMRX_LAST_WORD || level_r > 4'h1
                || lvl_inc) begin
                busy_nxt = 1'b1;
                st_nxt   = IMRX_F_READ;
                cnt_nxt  = `IMRX_LOW_FETCH_CYC - 3'h1 - {2'h0, fast};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r     <= IMRX_F_IDLE;
            rslot_r  <= 3'h0;
            rword_r  <= 3'h0;
            touch_r  <= 1'b0;
            skip_r   <= 1'b0;
            cnt_r    <= 3'h0;
            busy_r   <= 1'b0;
            sdone_r  <= 1'b0;
            data_r   <= 32'h0000_0000;
            crc_hd_r <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            rslot_r  <= rslot_nxt;
            rword_r  <= rword_nxt;
            touch_r  <= touch_nxt;
            skip_r   <= skip_nxt;
            cnt_r    <= cnt_nxt;
            busy_r   <= busy_nxt;
            sdone_r  <= sdone_nxt;
            data_r   <= data_nxt;
            crc_hd_r <= crc_hd_nxt;
        end
    end

    imrx_mem #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH),
        .AW    (6)
    ) u_mem (
        .clk   (hclk),
        .en    (!bypass),
        .we    (mem_we),
        .waddr ({wslot_r, wcnt_r}),
        .wdata (rx_word),
        .raddr ({rslot_r, rword_r}),
        .rdata (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_busy5; busy_r [*5] ##1 !busy_r; endsequence
    sequence s_busy4; busy_r [*4] ##1 !busy_r; endsequence
    sequence s_busy3; busy_r [*3] ##1 !busy_r; endsequence

    a_level_bound:
        assert property (level_r <= `IMRX_MSG_MAX)
        else $error("level above eight");
    a_sync_slow:
        assert property (sync_req && !fast |=> s_busy5)
        else $error("slow sync fetch not five cycles");
    a_sync_fast:
        assert property (sync_req && fast |=> s_busy4)
        else $error("fast sync fetch not four cycles");
    a_lo_fast:
        assert property (rd_lo && fast && rword_r != `IMRX_LAST_WORD
                         |=> s_busy3)
        else $error("fast low fetch not three cycles");
    a_sync_done:
        assert property (sync_req && !fast |=> !sdone_r [*5] ##1 sdone_r)
        else $error("sync done not set after fetch");
    a_bypass_nowr:
        assert property (bypass |-> !mem_we ##1 level_r <= $past(level_r))
        else $error("buffer written in bypass");
    a_hdr_err:
        assert property (rx_msg_done && !bypass
                         |=> hdr_err_r == $past(crc_bad))
        else $error("header error not updated");
    a_aux_good:
        assert property (rx_msg_done && !bypass && !crc_bad
                         |=> aux_r == $past(rx_hdr_aux) && !status_valid
                         ##1 status_valid)
        else $error("auxiliary byte or valid blip wrong");
    a_data_hold:
        assert property (!busy_r |=> $stable(data_r))
        else $error("data changed without fetch");
    a_page_pins:
        assert property (working_inband_channel_sel
                         |=> ingress_mem_switch_page == $past(page_r[1])
                         && egress_mem_switch_page == $past(page_r[0]))
        else $error("page pins not following received page");

endmodule

`default_nettype wire

//--- testbench/imrx_peer.sv
// Purpose: Deframer stand-in that hands whole messages to the buffer.
// Assumes: Eight word pulses, then one done pulse with header and CRC.
// Notes:   Released lines show the inverse of their last value.
`timescale 1ns/1ns
`default_nettype none

module imrx_peer (
    input  wire logic        hclk,
    output logic             rx_word_valid,
    output logic [31:0]      rx_word,
    output logic             rx_msg_done,
    output logic [7:0]       rx_hdr_aux,
    output logic [1:0]       rx_hdr_link,
    output logic [1:0]       rx_hdr_page,
    output logic [2:0]       rx_hdr_user,
    output logic [15:0]      rx_crc_recv,
    output logic [15:0]      rx_crc_calc
);
    initial begin
        rx_word_valid = 1'b0;
        rx_word       = 32'h0000_0000;
        rx_msg_done   = 1'b0;
        rx_hdr_aux    = 8'h00;
        {rx_hdr_link, rx_hdr_page, rx_hdr_user} = 7'h00;
        {rx_crc_recv, rx_crc_calc} = 32'h0000_0000;
    end

    ////////////////////////////////////////
    // Words go out in order, then the header with the done pulse
    task automatic send(input logic [31:0] base, input logic [7:0] aux,
                        input logic [6:0] lpu, input logic [31:0] crc);
        for (int i = 0; i < 8; i++) begin
            @(posedge hclk);
            rx_word_valid <= 1'b1;
            rx_word       <= base + 32'(i) * 32'h0001_0001;
        end
        @(posedge hclk);
        rx_word_valid <= 1'b0;
        rx_word       <= ~rx_word;
        rx_msg_done   <= 1'b1;
        rx_hdr_aux    <= aux;
        {rx_hdr_link, rx_hdr_page, rx_hdr_user} <= lpu;
        {rx_crc_recv, rx_crc_calc} <= crc;
        @(posedge hclk);
        rx_msg_done   <= 1'b0;
        rx_hdr_aux    <= ~aux;
        {rx_hdr_link, rx_hdr_page, rx_hdr_user} <= ~lpu;
        {rx_crc_recv, rx_crc_calc} <= ~crc;
        @(posedge hclk);
    endtask
endmodule

`default_nettype wire

//--- testbench/tb.sv
// Purpose: Register-level test of the receive message buffer.
// Assumes: Peer model feeds whole messages on hclk.
// Notes:   Fixed message patterns, no random stimulus.
`timescale 1ns/1ns
`default_nettype none
`include "imrx_defines.svh"

module tb
    import imrx_pkg::*;
();
    localparam logic [29:0] HI = `IMRX_IDX_DATA_HI;
    localparam logic [29:0] LO = `IMRX_IDX_DATA_LO;
    localparam logic [29:0] CT = `IMRX_IDX_CTRL;
    localparam logic [29:0] AX = `IMRX_IDX_AUX;
    localparam logic [29:0] ST = `IMRX_IDX_STAT;
    localparam logic [31:0] MA = 32'h1a1a_0000;
    localparam logic [31:0] MC = 32'h3c3c_0000;
    localparam logic [31:0] MF = 32'h0a00_0000;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        rx_word_valid;
    logic [31:0] rx_word;
    logic        rx_msg_done;
    logic [7:0]  rx_hdr_aux;
    logic [1:0]  rx_hdr_link;
    logic [1:0]  rx_hdr_page;
    logic [2:0]  rx_hdr_user;
    logic [15:0] rx_crc_recv;
    logic [15:0] rx_crc_calc;
    logic        sel;
    logic        upin;
    logic        ipg;
    logic        epg;
    logic [31:0] rd;
    int          fails = 0;
    int          num_checks = 0;
    int          cyc = 0;

    imrx_top dut_u (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rx_word_valid,
        .rx_word, .rx_msg_done, .rx_hdr_aux, .rx_hdr_link, .rx_hdr_page,
        .rx_hdr_user, .rx_crc_recv, .rx_crc_calc,
        .working_inband_channel_sel(sel), .user_bit_output_pin(upin),
        .ingress_mem_switch_page(ipg), .egress_mem_switch_page(epg)
    );

    imrx_peer peer_u (
        .hclk, .rx_word_valid, .rx_word, .rx_msg_done, .rx_hdr_aux,
        .rx_hdr_link, .rx_hdr_page, .rx_hdr_user, .rx_crc_recv, .rx_crc_calc
    );

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end

    ////////////////////////////////////////
    task automatic results();
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic xfer(input logic [29:0] idx, input logic wr,
                        input logic [15:0] wd);
        int n;
        n = 0;
        haddr  <= {idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 32) begin
            n++;
            @(posedge hclk);
        end
        htrans <= 2'h0;
        hwdata <= {16'h0000, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 32) begin
            n++;
            @(posedge hclk);
        end
        rd = hrdata;
        chk("bus wait", 16'h0000, 16'(n / 32));
        chk("hresp", 16'h0000, {15'h0000, hresp});
    endtask

    task automatic rchk(input logic [29:0] idx, input string what,
                        input logic [15:0] exp);
        xfer(idx, 1'b0, 16'h0000);
        chk(what, exp, rd[15:0]);
    endtask

    task automatic ctl(input logic [15:0] v);
        xfer(CT, 1'b1, v);
        rchk(CT, "control", v);
    endtask

    task automatic stat(input logic [15:0] exp);
        int n;
        n = 0;
        do begin
            xfer(ST, 1'b0, 16'h0000);
            n++;
        end while ((rd[1] !== 1'b0 || rd[15] !== 1'b1) && n < 16);
        chk("status", exp, rd[15:0]);
    endtask

    task automatic sync(input logic [15:0] exp);
        xfer(ST, 1'b1, 16'h0001);
        xfer(ST, 1'b0, 16'h0000);
        chk("busy after sync", 16'h0002, rd[15:0] & 16'h0002);
        stat(exp);
    endtask

    task automatic rmsg(input logic [31:0] base, input int cnt,
                        input logic [15:0] smid, input logic [15:0] slast);
        logic [31:0] w;
        for (int i = 0; i < cnt; i++) begin
            w = base + 32'(i) * 32'h0001_0001;
            rchk(HI, "data high", w[31:16]);
            rchk(HI, "data high again", w[31:16]);
            rchk(LO, "data low", w[15:0]);
            stat((i == 7) ? slast : smid);
        end
    endtask

    task automatic pins(input logic [2:0] exp);
        chk("pins", {13'h0000, exp}, {13'h0000, upin, ipg, epg});
    endtask

    ////////////////////////////////////////
    initial begin
        hresetn = 1'b0;
        hsel    = 1'b1;
        haddr   = 32'h0000_0000;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0000_0000;
        sel     = 1'b1;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(CT, "control reset", 16'h0000);
        xfer(ST, 1'b0, 16'h0000);
        chk("status reset", 16'h0000, {1'b0, rd[14:0]});
        xfer(AX, 1'b0, 16'h0000);
        chk("aux reset", 16'h0000, {8'h00, rd[7:0]});
        rchk(30'h0000_0098, "unmapped", 16'h0000);
        $display("test reset done");
        ctl(16'h0001);
        peer_u.send(MF, 8'hee, 7'h7f, 32'h1234_1234);
        stat(16'h8000);
        $display("test bypass done");
        ctl(16'h0002);
        peer_u.send(MA, 8'h5a, 7'h55, 32'h2c48_1234);
        stat(16'hd504);
        rchk(AX, "aux good", 16'h805a);
        pins(3'h6);
        ctl(16'h0000);
        peer_u.send(32'h2b2b_0000, 8'h33, 7'h2a, 32'h1235_1234);
        stat(16'hd548);
        rchk(AX, "aux kept", 16'h805a);
        sel <= 1'b0;
        peer_u.send(MC, 8'h11, 7'h60, 32'h4321_4321);
        stat(16'he00c);
        pins(3'h6);
        sel <= 1'b1;
        rchk(AX, "aux new", 16'h8011);
        pins(3'h0);
        $display("test headers done");
        ctl(16'h0004);
        sync(16'he00d);
        rmsg(MA, 8, 16'he00d, 16'he089);
        stat(16'he089);
        ctl(16'h0000);
        sync(16'he089);
        sync(16'he005);
        rmsg(MC, 1, 16'he005, 16'he005);
        $display("test read done");
        for (int k = 0; k < 9; k++) begin
            peer_u.send(MF + 32'(k) * 32'h0100_0000, 8'(k), 7'h00,
                        32'h0000_0000);
        end
        stat(16'h8021);
        rchk(AX, "aux last", 16'h8008);
        sync(16'h801d);
        rmsg(MF, 8, 16'h801d, 16'h8019);
        stat(16'h8019);
        $display("test fill done");
        results();
    end
endmodule

`default_nettype wire
